// ---- src/scpm_regs.svh ----
`ifndef SCPM_REGS_SVH
`define SCPM_REGS_SVH
`define SCPM_ADR_CLKCTRL    4'h0
`define SCPM_ADR_PSMODE     4'h1
`define SCPM_ADR_STANDBY    4'h2
`define SCPM_ADR_PERSEL     4'h3
`define SCPM_ADR_STATUS     4'h4
`define SCPM_DIV_LSB        0
`define SCPM_DIV_MSB        2
`define SCPM_SUBSEL_BIT     3
`define SCPM_MSTOP_BIT      4
`define SCPM_PSM_BIT        0
`define SCPM_STP_BIT        1
`define SCPM_MASKABLE_IRQ_DISABLE_BIT       4
`define SCPM_NMI_SRC0_MASK_BIT      5
`define SCPM_NMI_SRC2_MASK_BIT      6
`define SCPM_CLKCTRL_RST    8'h03
`define SCPM_SW_STAGES      2
`define SCPM_WAKE_SRC       11
`endif

// ---- src/scpm_pkg.sv ----
package scpm_pkg;
    typedef enum logic [1:0] {
        SCPM_NORMAL  = 2'b00,
        SCPM_SUBCLK  = 2'b01,
        SCPM_SUBIDLE = 2'b10
    } scpm_mode_t;

    typedef struct packed {
        logic wd2_nmi;
        logic pin_nmi;
        logic [7:0] ext_irq;
        logic periph_irq;
    } scpm_wake_t;
endpackage : scpm_pkg

// ---- src/scpm_clk_if.sv ----
`timescale 1ns/1ns
interface scpm_clk_if;
    logic main_clk;
    logic sub_clk;
    logic sel_sub;
    logic sys_clk;
    logic on_sub;

    modport ctrl (
        output sel_sub,
        input  on_sub
    );
    modport mux (
        input  main_clk,
        input  sub_clk,
        input  sel_sub,
        output sys_clk,
        output on_sub
    );
endinterface : scpm_clk_if

// ---- src/scpm_clk_switch.sv ----
`timescale 1ns/1ns
`include "scpm_regs.svh"
// Glitch-free source switch: each leg disables before the other enables.
module scpm_clk_switch (
    input wire logic rst_i,
    scpm_clk_if.mux  ck
);
    import scpm_pkg::*;

    logic [`SCPM_SW_STAGES-1:0] m_en_q;
    logic [`SCPM_SW_STAGES-1:0] s_en_q;

    // Enables change on falling edge of their own clock only
    // Reset is sampled here too: an async clear would cut a high phase
    always_ff @(negedge ck.main_clk) begin
        if (rst_i) begin
            m_en_q <= '0;
        end else begin
            m_en_q <= {m_en_q[0], ~ck.sel_sub & ~s_en_q[`SCPM_SW_STAGES-1]};
        end
    end

    always_ff @(negedge ck.sub_clk) begin
        if (rst_i) begin
            s_en_q <= '0;
        end else begin
            s_en_q <= {s_en_q[0], ck.sel_sub & ~m_en_q[`SCPM_SW_STAGES-1]};
        end
    end

    assign ck.sys_clk = (ck.main_clk & m_en_q[`SCPM_SW_STAGES-1]) |
                        (ck.sub_clk & s_en_q[`SCPM_SW_STAGES-1]);
    assign ck.on_sub  = s_en_q[`SCPM_SW_STAGES-1];
endmodule : scpm_clk_switch

// ---- src/scpm_top.sv ----
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "scpm_regs.svh"
module scpm_top (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wdt1_rst_i,
    input  wire logic                main_clk_i,
    input  wire logic                sub_clk_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire scpm_pkg::scpm_wake_t wake_raw_i,
    input  wire logic [3:0]          irq_prio_i,
    input  wire logic [3:0]          cur_prio_i,
    input  wire logic                in_handler_i,
    output logic                     main_osc_en_o,
    output logic                     sys_clk_o,
    output logic                     cpu_clk_en_o,
    output logic                     periph_clk_en_o,
    output logic [2:0]               sysclk_divider_sel_o,
    output logic                     irq_ack_o,
    output logic                     irq_pending_o,
    output logic [7:0]               unit_run_o
);
    import scpm_pkg::*;

    // Selector bits for the units that may run with the main clock stopped
    localparam int PS_SER_EXT  = 0;
    localparam int PS_UART_EXT = 1;
    localparam int PS_TMB_OSC  = 2;
    localparam int PS_WT_SUB   = 3;
    localparam int PS_CTB_WT   = 4;
    localparam int PS_RTO_TRG  = 5;
    localparam int PS_BT_EN    = 6;

    typedef struct packed {
        scpm_mode_t  mode;
        logic [7:0]  clkctrl;
        logic [7:0]  psmode;
        logic [7:0]  standby;
        logic [7:0]  persel;
        scpm_wake_t  w1;
        scpm_wake_t  w2;
        logic [31:0] rdat;
        logic        ack;
        logic        iack;
        logic        ipend;
        logic        sub_s1;
        logic        sub_s2;
    } scpm_state_t;

    scpm_state_t s_q;
    scpm_state_t s_d;
    scpm_clk_if  ck ();
    logic        wake;
    logic        nmi_ok;
    logic        mi_ok;
    logic        wr;
    logic        rd;
    logic        mstop;

    assign ck.main_clk = main_clk_i;
    assign ck.sub_clk  = sub_clk_i;

    scpm_clk_switch u_sw (
        .rst_i (rst_i),
        .ck    (ck.mux)
    );

    assign mstop = s_q.clkctrl[`SCPM_MSTOP_BIT];
    // Masked sources never wake the device
    assign nmi_ok = (s_q.w2.pin_nmi & ~s_q.standby[`SCPM_NMI_SRC0_MASK_BIT]) |
                    (s_q.w2.wd2_nmi & ~s_q.standby[`SCPM_NMI_SRC2_MASK_BIT]);
    assign mi_ok  = (|s_q.w2.ext_irq | s_q.w2.periph_irq) &
                    ~s_q.standby[`SCPM_MASKABLE_IRQ_DISABLE_BIT];
    assign wake   = nmi_ok | mi_ok;
    assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack & wb_sel_i[0];
    assign rd     = wb_cyc_i & wb_stb_i & ~s_q.ack;

    always_comb begin
        s_d      = s_q;
        s_d.w1   = wake_raw_i;
        s_d.w2   = s_q.w1;
        // Mux state lives on the oscillator clocks; two flops before use
        s_d.sub_s1 = ck.on_sub;
        s_d.sub_s2 = s_q.sub_s1;
        s_d.ack  = wb_cyc_i & wb_stb_i & ~s_q.ack;
        s_d.iack = 1'b0;
        s_d.rdat = '0;
        if (rd) begin
            unique case (wb_adr_i)
                `SCPM_ADR_CLKCTRL: s_d.rdat = {24'h0, s_q.clkctrl};
                `SCPM_ADR_PSMODE:  s_d.rdat = {24'h0, s_q.psmode};
                `SCPM_ADR_STANDBY: s_d.rdat = {24'h0, s_q.standby};
                `SCPM_ADR_PERSEL:  s_d.rdat = {24'h0, s_q.persel};
                `SCPM_ADR_STATUS:  s_d.rdat = {29'h0, s_q.sub_s2, s_q.mode};
                default:           s_d.rdat = '0;
            endcase
        end
        if (wr) begin
            unique case (wb_adr_i)
                `SCPM_ADR_CLKCTRL: s_d.clkctrl = wb_dat_i[7:0];
                `SCPM_ADR_PSMODE:  s_d.psmode  = wb_dat_i[7:0];
                `SCPM_ADR_STANDBY: s_d.standby = wb_dat_i[7:0] &
                                   ~(8'h1 << `SCPM_STP_BIT);
                `SCPM_ADR_PERSEL:  s_d.persel  = wb_dat_i[7:0];
                default: ;
            endcase
        end
        unique case (s_q.mode)
            SCPM_NORMAL: begin
                if (s_d.clkctrl[`SCPM_SUBSEL_BIT]) begin
                    s_d.mode = SCPM_SUBCLK;
                end
            end
            SCPM_SUBCLK: begin
                if (!s_d.clkctrl[`SCPM_SUBSEL_BIT]) begin
                    s_d.mode = SCPM_NORMAL;
                end else if (wr && wb_adr_i == `SCPM_ADR_STANDBY &&
                             wb_dat_i[`SCPM_STP_BIT] &&
                             !s_q.psmode[`SCPM_PSM_BIT]) begin
                    s_d.mode = SCPM_SUBIDLE;
                end
            end
            SCPM_SUBIDLE: begin
                if (wake) begin
                    s_d.mode = SCPM_SUBCLK;
                    // Inside a handler, a maskable request of equal or lower priority only wakes; left pending
                    if (nmi_ok || !in_handler_i ||
                        irq_prio_i < cur_prio_i) begin
                        s_d.iack  = 1'b1;
                        s_d.ipend = 1'b0;
                    end else begin
                        s_d.ipend = 1'b1;
                    end
                end
            end
            default: s_d.mode = SCPM_NORMAL;
        endcase
        if (s_q.mode != SCPM_SUBIDLE && !wake) begin
            s_d.ipend = 1'b0;
        end
    end

    // Watchdog 1 reset does not leave sub-IDLE
    always_ff @(posedge clk_i) begin
        if (rst_i || (wdt1_rst_i && s_q.mode != SCPM_SUBIDLE)) begin
            s_q         <= '0;
            s_q.mode    <= SCPM_NORMAL;
            s_q.clkctrl <= `SCPM_CLKCTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign ck.sel_sub           = s_q.mode != SCPM_NORMAL;
    assign sys_clk_o            = ck.sys_clk;
    assign main_osc_en_o        = ~mstop;
    // Oscillators keep running; only consumer clocks gate
    assign cpu_clk_en_o         = s_q.mode != SCPM_SUBIDLE;
    assign periph_clk_en_o      = s_q.mode != SCPM_SUBIDLE;
    assign sysclk_divider_sel_o = s_q.clkctrl[`SCPM_DIV_MSB:`SCPM_DIV_LSB];
    assign irq_ack_o            = s_q.iack;
    assign irq_pending_o        = s_q.ipend;
    assign wb_dat_o             = s_q.rdat;
    assign wb_ack_o             = s_q.ack;

    // Per-unit run enables; with main stopped only alternate clocks qualify
    always_comb begin
        unit_run_o    = '0;
        unit_run_o[0] = ~mstop | s_q.persel[PS_SER_EXT];
        unit_run_o[1] = ~mstop | s_q.persel[PS_SER_EXT];
        unit_run_o[2] = ~mstop | s_q.persel[PS_UART_EXT];
        unit_run_o[3] = ~mstop | s_q.persel[PS_TMB_OSC];
        unit_run_o[4] = ~mstop | s_q.persel[PS_WT_SUB];
        unit_run_o[5] = ~mstop | (s_q.persel[PS_CTB_WT] &
                                  s_q.persel[PS_WT_SUB]);
        unit_run_o[6] = ~mstop | (s_q.persel[PS_RTO_TRG] &
                                  s_q.persel[PS_BT_EN]);
        unit_run_o[7] = ~mstop & (s_q.mode != SCPM_SUBIDLE);
    end

    a_subidle_entry: assert property (@(posedge clk_i)
        disable iff (rst_i || wdt1_rst_i)
        (s_q.mode == SCPM_SUBCLK && wr && wb_adr_i == `SCPM_ADR_STANDBY &&
         wb_dat_i[`SCPM_STP_BIT] && !s_q.psmode[`SCPM_PSM_BIT] &&
         s_d.clkctrl[`SCPM_SUBSEL_BIT]) |=> s_q.mode == SCPM_SUBIDLE)
        else $error("sub-idle not entered");
    a_no_entry_normal: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.mode == SCPM_NORMAL |=> s_q.mode != SCPM_SUBIDLE)
        else $error("sub-idle from normal");
    a_wake_to_sub: assert property (@(posedge clk_i) disable iff (rst_i || wdt1_rst_i)
        (s_q.mode == SCPM_SUBIDLE && wake) |=> s_q.mode == SCPM_SUBCLK)
        else $error("wake did not return to subclock");
    a_masked_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == SCPM_SUBIDLE && !wake) |=> s_q.mode == SCPM_SUBIDLE)
        else $error("left sub-idle without source");
    a_clear_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.mode == SCPM_SUBCLK && !s_d.clkctrl[`SCPM_SUBSEL_BIT])
        |=> s_q.mode == SCPM_NORMAL)
        else $error("subclock held after clear");
    a_gate_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.mode == SCPM_SUBIDLE |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("clock not gated in sub-idle");
    a_osc_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(mstop) |-> !main_osc_en_o)
        else $error("main oscillator still running");
    a_low_prio: assert property (@(posedge clk_i) disable iff (rst_i || wdt1_rst_i)
        (s_q.mode == SCPM_SUBIDLE && wake && !nmi_ok && in_handler_i &&
         irq_prio_i >= cur_prio_i) |=> !irq_ack_o && irq_pending_o)
        else $error("low priority request acknowledged");
    a_wt_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (mstop && !s_q.persel[PS_WT_SUB]) |-> !unit_run_o[4] && !unit_run_o[5])
        else $error("watch timer runs without subclock");
    a_reset_normal: assert property (@(posedge clk_i)
        rst_i |=> s_q.mode == SCPM_NORMAL && main_osc_en_o)
        else $error("reset did not force normal");
endmodule : scpm_top

// ---- bench/scpm_osc_model.sv ----
`timescale 1ns/1ns
// Raw oscillators, faster than real so the run stays short
module scpm_osc_model (
    input  wire logic main_en_i,
    output logic      main_clk_o,
    output logic      sub_clk_o
);
    initial begin
        main_clk_o = 1'b0;
        // Starts high so its first fall lands inside the opening reset
        sub_clk_o  = 1'b1;
    end
    // Stopped main oscillator parks low, never mid-level
    always #20 main_clk_o = main_en_i ? ~main_clk_o : 1'b0;
    always #100 sub_clk_o = ~sub_clk_o;
endmodule : scpm_osc_model

// ---- bench/scpm_top_tb.sv ----
`timescale 1ns/1ns
module scpm_top_tb;
    import scpm_pkg::*;
    typedef struct packed {
        logic        w;
        logic [3:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } scpm_row_t;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        wdt1_rst_i = 1'b0;
    logic        req        = 1'b0;
    logic        we         = 1'b0;
    logic [3:0]  adr        = 4'h0;
    logic [31:0] dat        = 32'h0;
    logic [3:0]  irq_prio   = 4'h0;
    logic [3:0]  cur_prio   = 4'h0;
    logic        in_handler = 1'b0;
    scpm_wake_t  wake       = '0;
    logic [31:0] rd, wb_dat_o;
    logic        wb_ack_o, main_clk, sub_clk, main_en, sys_clk;
    logic        cpu_en, per_en, ack, pend;
    logic [2:0]  div;
    logic [7:0]  run;
    int          fails = 0, tests_run = 0, cycles = 0, acks = 0;
    int          glitch = 0, a;
    realtime     t_hi = 0;
    scpm_row_t   rows[11] = '{
        '{1'b0, 4'h0, 32'h0, 32'h3}, '{1'b0, 4'h4, 32'h0, 32'h0},
        '{1'b1, 4'h2, 32'h2, 32'h0}, '{1'b0, 4'h4, 32'h0, 32'h0},
        '{1'b1, 4'h3, 32'h7f, 32'h0}, '{1'b0, 4'h3, 32'h0, 32'h7f},
        '{1'b1, 4'h5, 32'hff, 32'h0}, '{1'b0, 4'h5, 32'h0, 32'h0},
        '{1'b1, 4'h1, 32'h1, 32'h0}, '{1'b0, 4'h1, 32'h0, 32'h1},
        '{1'b1, 4'h0, 32'hb, 32'h0}};
    logic [7:0]  pv[9] = '{8'h7f, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                           8'h18, 8'h20, 8'h60};
    logic [7:0]  ev[9] = '{8'h7f, 8'h03, 8'h04, 8'h08, 8'h10, 8'h00,
                           8'h30, 8'h00, 8'h40};
    logic [10:0] srcs[4] = '{11'h400, 11'h200, 11'h100, 11'h001};

    scpm_top scpm_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .wdt1_rst_i(wdt1_rst_i), .main_clk_i(main_clk), .sub_clk_i(sub_clk),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wake_raw_i(wake), .irq_prio_i(irq_prio),
        .cur_prio_i(cur_prio), .in_handler_i(in_handler),
        .main_osc_en_o(main_en), .sys_clk_o(sys_clk), .cpu_clk_en_o(cpu_en),
        .periph_clk_en_o(per_en), .sysclk_divider_sel_o(div),
        .irq_ack_o(ack), .irq_pending_o(pend), .unit_run_o(run));
    scpm_osc_model scpm_osc_model_i (.main_en_i(main_en),
        .main_clk_o(main_clk), .sub_clk_o(sub_clk));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Hang guard: whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (ack === 1'b1) acks++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end
    // Shortest high phase must stay a full oscillator half period
    always @(posedge sys_clk) t_hi = $realtime;
    always @(negedge sys_clk) if ($realtime - t_hi < 19.0) glitch++;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    task wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we  <= w;
        adr <= ad;
        dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 100);
        if (wb_ack_o !== 1'b1) fails++;
        rd = wb_dat_o;
        req <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Mux handover is slow, so status is polled under a bound
    task poll(input logic [3:0] ad, input logic [31:0] m,
              input logic [31:0] e);
        int n;
        n = 0;
        do wb(1'b0, ad, 32'h0); while ((rd & m) !== e && n++ < 60);
        chk(rd & m, e);
    endtask : poll
    task wake_up(input logic [10:0] w);
        int n;
        n = 0;
        wake <= w;
        do @(posedge clk_i); while (cpu_en !== 1'b1 && n++ < 30);
    endtask : wake_up
    task done(input string s);
        $display("test %s finished, %0d checks so far", s, tests_run);
    endtask : done
    task results;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        idle(12);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e);
        end
        poll(4'h4, 32'h7, 32'h5);
        chk(div, 3'h3);
        wb(1'b1, 4'h0, 32'h1b);
        chk(main_en, 1'b0);
        done("regs");
        foreach (pv[i]) begin
            wb(1'b1, 4'h3, {24'h0, pv[i]});
            idle(2);
            chk(run[6:0], ev[i][6:0]);
        end
        chk(run[7], 1'b0);
        wb(1'b1, 4'h1, 32'h1);
        wb(1'b1, 4'h2, 32'h2);
        idle(3);
        chk(cpu_en, 1'b1);
        wb(1'b1, 4'h1, 32'h0);
        done("units");
        foreach (srcs[k]) begin
            a = acks;
            wb(1'b1, 4'h2, 32'h2);
            idle(5);
            chk({cpu_en, per_en}, 2'b00);
            wake_up(srcs[k]);
            chk(cpu_en, 1'b1);
            wake <= '0;
            idle(4);
            chk(acks - a, 1);
            poll(4'h4, 32'h3, 32'h1);
        end
        in_handler <= 1'b1;
        cur_prio   <= 4'h2;
        irq_prio   <= 4'h5;
        a = acks;
        wb(1'b1, 4'h2, 32'h2);
        idle(3);
        wake_up(11'h001);
        idle(4);
        chk({pend, 1'b0}, 2'b10);
        chk(acks - a, 0);
        wake       <= '0;
        in_handler <= 1'b0;
        done("wake");
        wb(1'b1, 4'h0, 32'h0b);
        idle(20);
        wb(1'b1, 4'h0, 32'h03);
        poll(4'h4, 32'h7, 32'h0);
        wb(1'b1, 4'h0, 32'h0b);
        poll(4'h4, 32'h7, 32'h5);
        wb(1'b1, 4'h2, 32'h72);
        wake_up(11'h7ff);
        chk(cpu_en, 1'b0);
        wdt1_rst_i <= 1'b1;
        idle(2);
        wdt1_rst_i <= 1'b0;
        idle(4);
        chk(cpu_en, 1'b0);
        wake  <= '0;
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        idle(2);
        chk({cpu_en, main_en}, 2'b11);
        chk(run[7], 1'b1);
        poll(4'h0, 32'hff, 32'h03);
        poll(4'h4, 32'h3, 32'h0);
        chk(glitch, 0);
        done("reset");
        results();
    end
endmodule : scpm_top_tb
